// [common/hflr_pkg.sv]
package hflr_pkg;
	localparam int EXP_W = 7;
	localparam int FRAC_W = 24;
	localparam int DBL_FRAC_W = 56;
	localparam int GUARD_W = 32;
	localparam int WORK_W = FRAC_W + GUARD_W;
	localparam int WORK_DIGITS = WORK_W / 4;
	localparam int TEXP_W = 10;
	localparam int NUM_FREGS = 8;
	localparam int SIGN_POS = 31;
	localparam int EXP_LSB = 24;
	localparam int PSW_UNDERFLOW_BIT = 19;
	localparam logic signed [TEXP_W-1:0] EXP_BIAS = 10'sh040;
	localparam logic signed [TEXP_W-1:0] EXP_MAX = 10'sh03F;
	localparam logic signed [TEXP_W-1:0] EXP_MIN = -10'sh040;
	localparam logic [7:0] OPC_LOAD_FLOAT_MEMORY = 8'h68;
	localparam logic [3:0] ROUND_TRUNC_MAX = 4'h7;
	localparam logic [3:0] ROUND_HALF = 4'h8;
	localparam logic [FRAC_W-1:0] FRAC_CARRY_VAL = 24'h10_0000;
	localparam logic [31:0] TRUE_ZERO = 32'h0000_0000;
	// condition code order is C V G L, msb first
	localparam logic [3:0] CC_ZERO = 4'h0;
	localparam logic [3:0] CC_LESS = 4'h1;
	localparam logic [3:0] CC_GREATER = 4'h2;
	localparam logic [3:0] CC_UNDERFLOW = 4'h4;
	localparam logic [3:0] CC_OVF_LESS = 4'h5;
	localparam logic [3:0] CC_OVF_GREATER = 4'h6;
	localparam logic [3:0] CC_RESET = 4'h0;

	typedef enum logic [2:0] {
		OP_NONE,
		OP_LOAD_FLOAT_MEMORY,
		OP_LOAD_FLOAT_REGISTER,
		OP_LOAD_FLOAT_FROM_GENERAL,
		OP_LOAD_FLOAT_POSITIVE,
		OP_LOAD_GENERAL_FROM_FLOAT,
		OP_ROUND_RESULT
	} hflr_op_t;
endpackage

// [design/hflr_norm.sv]
module hflr_norm import hflr_pkg::*; (
	input wire logic signed [TEXP_W-1:0] expIn,
	input wire logic [WORK_W-1:0] fracIn,
	output logic signed [TEXP_W-1:0] expOut,
	output logic [WORK_W-1:0] fracOut,
	output logic isZero
);
	function automatic logic [3:0] leadZeroDigits(input logic [WORK_W-1:0] f);
		logic [3:0] n;
		logic found;
		n = 4'h0;
		found = 1'b0;
		for (int i = WORK_DIGITS - 1; i >= 0; i--) begin
			if (!found) begin
				if (f[i*4 +: 4] != 4'h0) begin
					found = 1'b1;
				end else begin
					n = n + 4'h1;
				end
			end
		end
		return n;
	endfunction

	wire logic [3:0] lz;
	assign lz = leadZeroDigits(fracIn);
	assign isZero = (fracIn == '0);
	// one digit shift per exponent step, done in one pass
	assign fracOut = isZero ? '0 : fracIn << {lz, 2'b00};
	assign expOut = expIn - signed'({{(TEXP_W-4){1'b0}}, lz});
endmodule

// [design/hflr_round.sv]
module hflr_round import hflr_pkg::*; (
	input wire logic signed [TEXP_W-1:0] expIn,
	input wire logic [WORK_W-1:0] fracIn,
	output logic signed [TEXP_W-1:0] expOut,
	output logic [FRAC_W-1:0] fracOut
);
	wire logic [FRAC_W-1:0] frac;
	wire logic [3:0] leadGuard;
	wire logic [GUARD_W-5:0] restGuard;
	wire logic [FRAC_W:0] incSum;
	wire logic forceLsb;
	wire logic doInc;
	assign frac = fracIn[WORK_W-1 -: FRAC_W];
	assign leadGuard = fracIn[GUARD_W-1 -: 4];
	assign restGuard = fracIn[GUARD_W-5:0];
	assign forceLsb = (leadGuard == ROUND_HALF) && (restGuard == '0);
	assign doInc = (leadGuard > ROUND_TRUNC_MAX) && !forceLsb;
	assign incSum = {1'b0, frac} + {{FRAC_W{1'b0}}, 1'b1};
	// low guard digits only pick out the exact-half case, then are dropped
	assign fracOut = forceLsb ? (frac | {{(FRAC_W-1){1'b0}}, 1'b1}) :
		!doInc ? frac :
		incSum[FRAC_W] ? FRAC_CARRY_VAL : incSum[FRAC_W-1:0];
	assign expOut = (doInc && incSum[FRAC_W]) ? expIn + 10'sh001 : expIn;
endmodule

// [design/hflr_unit.sv]
module hflr_unit import hflr_pkg::*; (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic opValid,
	input wire logic [7:0] opCode,
	input wire hflr_op_t opSel,
	input wire logic [3:0] firstRegisterField,
	input wire logic [3:0] secondRegisterField,
	input wire logic [31:0] memOperand,
	input wire logic [31:0] generalOperand,
	input wire logic [0:31] programStatusWord,
	input wire logic intSign,
	input wire logic signed [TEXP_W-1:0] intExp,
	input wire logic [FRAC_W-1:0] intFrac,
	input wire logic [GUARD_W-1:0] intGuard,
	input wire logic dblWrite,
	input wire logic [3:0] dblField,
	input wire logic [63:0] dblData,
	input wire logic [3:0] readField,
	output logic done_r,
	output logic [3:0] condCode_r,
	output logic fault_r,
	output logic faultOverflow_r,
	output logic faultUnderflow_r,
	output logic destWrite_r,
	output logic [31:0] destData_r,
	output logic genWrite_r,
	output logic [3:0] genField_r,
	output logic [31:0] genData_r,
	output logic [31:0] readSingle_r,
	output logic [63:0] readDouble_r
);
	// register numbers are even; bit 0 of a field is ignored
	function automatic logic [2:0] regIndex(input logic [3:0] field);
		return field[3:1];
	endfunction

	function automatic logic [3:0] signCode(input logic neg);
		return neg ? CC_LESS : CC_GREATER;
	endfunction

	logic [31:0] singleRegs [NUM_FREGS];
	logic [63:0] doubleRegs [NUM_FREGS];

	// effective operation: the memory opcode wins over the selector
	wire hflr_op_t op;
	assign op = hflr_op_t'((opCode == OPC_LOAD_FLOAT_MEMORY) ? OP_LOAD_FLOAT_MEMORY : opSel);

	wire logic isLoad;
	wire logic isRound;
	wire logic toGeneral;
	assign isLoad = (op == OP_LOAD_FLOAT_MEMORY) || (op == OP_LOAD_FLOAT_REGISTER) ||
		(op == OP_LOAD_FLOAT_FROM_GENERAL) || (op == OP_LOAD_FLOAT_POSITIVE);
	assign isRound = (op == OP_ROUND_RESULT);
	// only the general move sends its first field to the general file
	assign toGeneral = (op == OP_LOAD_GENERAL_FROM_FLOAT);

	wire logic [2:0] srcIdx;
	wire logic [2:0] dstIdx;
	wire logic [31:0] srcRegWord;
	assign srcIdx = regIndex(secondRegisterField);
	assign dstIdx = regIndex(firstRegisterField);
	assign srcRegWord = singleRegs[srcIdx];

	wire logic [31:0] loadWord;
	assign loadWord = (op == OP_LOAD_FLOAT_MEMORY) ? memOperand :
		(op == OP_LOAD_FLOAT_FROM_GENERAL) ? generalOperand : srcRegWord;

	// field split of a single word
	wire logic loadSign;
	wire logic [EXP_W-1:0] loadExpField;
	wire logic [FRAC_W-1:0] loadFrac;
	wire logic signed [TEXP_W-1:0] loadTrueExp;
	assign loadSign = (op == OP_LOAD_FLOAT_POSITIVE) ? 1'b0 : loadWord[SIGN_POS];
	assign loadExpField = loadWord[SIGN_POS-1:EXP_LSB];
	assign loadFrac = loadWord[FRAC_W-1:0];
	assign loadTrueExp = signed'({{(TEXP_W-EXP_W){1'b0}}, loadExpField}) - EXP_BIAS;

	// loads enter with zero guard digits, so rounding never changes them
	wire logic workSign;
	wire logic signed [TEXP_W-1:0] workExp;
	wire logic [WORK_W-1:0] workFrac;
	assign workSign = isRound ? intSign : loadSign;
	assign workExp = isRound ? intExp : loadTrueExp;
	assign workFrac = isRound ? {intFrac, intGuard} : {loadFrac, {GUARD_W{1'b0}}};

	wire logic signed [TEXP_W-1:0] normExp;
	wire logic [WORK_W-1:0] normFrac;
	wire logic normZero;

	hflr_norm u_norm (
		.expIn(workExp),
		.fracIn(workFrac),
		.expOut(normExp),
		.fracOut(normFrac),
		.isZero(normZero)
	);

	wire logic signed [TEXP_W-1:0] rndExp;
	wire logic [FRAC_W-1:0] rndFrac;

	hflr_round u_round (
		.expIn(normExp),
		.fracIn(normFrac),
		.expOut(rndExp),
		.fracOut(rndFrac)
	);

	// exceptions: underflow judged after normalizing, overflow after rounding
	wire logic underflow;
	wire logic overflow;
	wire logic underflowTrap;
	assign underflow = !normZero && (normExp < EXP_MIN);
	assign overflow = !normZero && !underflow && (rndExp > EXP_MAX);
	assign underflowTrap = underflow && programStatusWord[PSW_UNDERFLOW_BIT];

	wire logic signed [TEXP_W-1:0] biasedExp;
	wire logic [EXP_W-1:0] resultExpField;
	wire logic [31:0] resultWord;
	assign biasedExp = rndExp + EXP_BIAS;
	assign resultExpField = biasedExp[EXP_W-1:0];
	assign resultWord = (normZero || underflow) ? TRUE_ZERO :
		{workSign, resultExpField, rndFrac};

	wire logic [3:0] ovfCode;
	wire logic [3:0] floatCode;
	assign ovfCode = workSign ? CC_OVF_LESS : CC_OVF_GREATER;
	assign floatCode = overflow ? ovfCode :
		underflow ? CC_UNDERFLOW :
		normZero ? CC_ZERO : signCode(workSign);

	// general move: value passes unchanged, code from sign and magnitude
	wire logic srcIsZero;
	wire logic srcNeg;
	wire logic [3:0] moveCode;
	assign srcIsZero = (srcRegWord == TRUE_ZERO);
	assign srcNeg = srcRegWord[SIGN_POS];
	assign moveCode = srcIsZero ? CC_ZERO : signCode(srcNeg);

	wire logic floatOp;
	wire logic faultNow;
	wire logic writeNow;
	assign floatOp = opValid && (isLoad || isRound);
	assign faultNow = floatOp && (overflow || underflowTrap);
	// a trapped result leaves destination and operands as they were
	assign writeNow = floatOp && !overflow && !underflowTrap;

	// next values; each output flop keeps a block of its own
	wire logic takeMove;
	assign takeMove = opValid && toGeneral;

	wire logic done_nxt;
	assign done_nxt = opValid && (op != OP_NONE);

	wire logic [3:0] condCode_nxt;
	assign condCode_nxt = takeMove ? moveCode :
		floatOp ? floatCode : condCode_r;

	wire logic fault_nxt;
	wire logic faultOverflow_nxt;
	wire logic faultUnderflow_nxt;
	assign fault_nxt = faultNow;
	assign faultOverflow_nxt = faultNow && overflow;
	assign faultUnderflow_nxt = faultNow && underflowTrap;

	wire logic destWrite_nxt;
	wire logic [31:0] destData_nxt;
	assign destWrite_nxt = writeNow;
	assign destData_nxt = writeNow ? resultWord : destData_r;

	wire logic genWrite_nxt;
	wire logic [3:0] genField_nxt;
	wire logic [31:0] genData_nxt;
	assign genWrite_nxt = takeMove;
	assign genField_nxt = takeMove ? firstRegisterField : genField_r;
	assign genData_nxt = takeMove ? srcRegWord : genData_r;

	wire logic [2:0] readIdx;
	wire logic [2:0] dblIdx;
	wire logic [31:0] readSingle_nxt;
	wire logic [63:0] readDouble_nxt;
	assign readIdx = regIndex(readField);
	assign dblIdx = regIndex(dblField);
	assign readSingle_nxt = singleRegs[readIdx];
	assign readDouble_nxt = doubleRegs[readIdx];

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			done_r <= 1'b0;
		end else begin
			done_r <= done_nxt;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			condCode_r <= CC_RESET;
		end else begin
			condCode_r <= condCode_nxt;
		end
	end

	// fault cause stands with the pulse only
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			fault_r <= 1'b0;
		end else begin
			fault_r <= fault_nxt;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			faultOverflow_r <= 1'b0;
		end else begin
			faultOverflow_r <= faultOverflow_nxt;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			faultUnderflow_r <= 1'b0;
		end else begin
			faultUnderflow_r <= faultUnderflow_nxt;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			destWrite_r <= 1'b0;
		end else begin
			destWrite_r <= destWrite_nxt;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			destData_r <= TRUE_ZERO;
		end else begin
			destData_r <= destData_nxt;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			genWrite_r <= 1'b0;
		end else begin
			genWrite_r <= genWrite_nxt;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			genField_r <= 4'h0;
		end else begin
			genField_r <= genField_nxt;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			genData_r <= TRUE_ZERO;
		end else begin
			genData_r <= genData_nxt;
		end
	end

	// single-precision file; the written value is the rounded result
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < NUM_FREGS; i++) begin
				singleRegs[i] <= TRUE_ZERO;
			end
		end else if (writeNow) begin
			singleRegs[dstIdx] <= resultWord;
		end
	end

	// double file is written raw; its arithmetic lives elsewhere
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < NUM_FREGS; i++) begin
				doubleRegs[i] <= 64'h0000_0000_0000_0000;
			end
		end else if (dblWrite) begin
			doubleRegs[dblIdx] <= dblData;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			readSingle_r <= TRUE_ZERO;
		end else begin
			readSingle_r <= readSingle_nxt;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			readDouble_r <= 64'h0000_0000_0000_0000;
		end else begin
			readDouble_r <= readDouble_nxt;
		end
	end
endmodule

// [tb/hflr_exc_model.sv]
module hflr_exc_model (
	input logic ref_clk,
	input logic nrst,
	input logic fault_r,
	input logic faultOverflow_r,
	input logic faultUnderflow_r,
	output int ovfSeen,
	output int unfSeen
);
	timeunit 1ns;
	timeprecision 1ps;
	// exception side takes each pulse once; a stretched pulse would count twice
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			ovfSeen <= 0;
			unfSeen <= 0;
		end else if (fault_r) begin
			ovfSeen <= ovfSeen + faultOverflow_r; // no mask on this side
			unfSeen <= unfSeen + faultUnderflow_r;
		end
	end
endmodule

// [tb/hflr_unit_assertions.sv]
module hflr_unit_chk import hflr_pkg::*; (
	input logic ref_clk,
	input logic nrst,
	input logic opValid,
	input hflr_op_t opSel,
	input logic [0:31] programStatusWord,
	input logic done_r,
	input logic [3:0] condCode_r,
	input logic fault_r,
	input logic faultOverflow_r,
	input logic faultUnderflow_r,
	input logic destWrite_r,
	input logic [31:0] destData_r
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	AST_DONE: assert property (opValid && opSel != OP_NONE |=> done_r)
		else $error("done missing");
	AST_FAULT_CAUSE: assert property (fault_r |-> $past(opValid) && (faultOverflow_r ^ faultUnderflow_r))
		else $error("fault cause wrong");
	AST_OVF_HOLD: assert property (faultOverflow_r |-> !destWrite_r && condCode_r[2] && fault_r)
		else $error("overflow wrote");
	AST_OVF_FAULT: assert property (done_r && condCode_r inside {4'h5, 4'h6} |-> faultOverflow_r)
		else $error("overflow not faulted");
	AST_UNF_TRAP: assert property (faultUnderflow_r |-> !destWrite_r && condCode_r == 4'h4 &&
		$past(programStatusWord[19]))
		else $error("underflow trap wrong");
	AST_UNF_MASK: assert property (done_r && condCode_r == 4'h4 && !fault_r |-> destWrite_r && destData_r == 32'h0)
		else $error("masked underflow wrong");
	AST_ZERO: assert property (destWrite_r && destData_r[23:0] == 24'h00_0000 |-> destData_r == 32'h0)
		else $error("not true zero");
	AST_NORM: assert property (destWrite_r && destData_r != 32'h0 |-> destData_r[23:20] != 4'h0)
		else $error("not normalized");
	AST_CC: assert property (destWrite_r && condCode_r != 4'h4 |-> condCode_r ==
		(destData_r == 32'h0 ? 4'h0 : destData_r[31] ? 4'h1 : 4'h2))
		else $error("code mismatch");
	AST_POS: assert property ($past(opValid && opSel == OP_LOAD_FLOAT_POSITIVE) |-> !condCode_r[0])
		else $error("positive load gave less");
	COV_OVF: cover property (fault_r && faultOverflow_r);
	COV_UNF: cover property (fault_r && faultUnderflow_r);
	COV_ZERO: cover property (destWrite_r && destData_r == 32'h0);
endmodule
bind hflr_unit hflr_unit_chk i_hflr_unit_chk (.ref_clk, .nrst, .opValid, .opSel, .programStatusWord, .done_r,
	.condCode_r, .fault_r, .faultOverflow_r, .faultUnderflow_r, .destWrite_r, .destData_r);

// [tb/tb.sv]
module tb import hflr_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
`define HFLR_CHK(n, e, a) begin totalChecks++; if ((a) !== (e)) begin miscompares++; \
	$display("BAD %s exp %h got %h", n, e, a); end end
	int miscompares = 0, totalChecks = 0, ovfSeen, unfSeen;
	logic ref_clk = 0, nrst = 0, opValid = 0, intSign = 0, dblWrite = 0;
	logic [7:0] opCode = 8'h00;
	hflr_op_t opSel = OP_NONE;
	logic [3:0] firstRegisterField = 4'h0, secondRegisterField = 4'h0, dblField = 4'h0, readField = 4'h0;
	logic [31:0] memOperand = 32'h0, generalOperand = 32'h0;
	logic [0:31] programStatusWord = 32'h0;
	logic signed [TEXP_W-1:0] intExp = '0;
	logic [FRAC_W-1:0] intFrac = '0;
	logic [GUARD_W-1:0] intGuard = '0;
	logic [63:0] dblData = 64'h0, readDouble_r;
	logic done_r, fault_r, faultOverflow_r, faultUnderflow_r, destWrite_r, genWrite_r;
	logic [3:0] condCode_r, genField_r;
	logic [31:0] destData_r, genData_r, readSingle_r;
	hflr_unit i_hflr_unit (.ref_clk, .nrst, .opValid, .opCode, .opSel, .firstRegisterField, .secondRegisterField,
		.memOperand, .generalOperand, .programStatusWord, .intSign, .intExp, .intFrac, .intGuard, .dblWrite,
		.dblField, .dblData, .readField, .done_r, .condCode_r, .fault_r, .faultOverflow_r, .faultUnderflow_r,
		.destWrite_r, .destData_r, .genWrite_r, .genField_r, .genData_r, .readSingle_r, .readDouble_r);
	hflr_exc_model i_hflr_exc_model (.ref_clk, .nrst, .fault_r, .faultOverflow_r, .faultUnderflow_r, .ovfSeen,
		.unfSeen);
	always #10 ref_clk = ~ref_clk;
	task automatic complete_run();
		$display("checks %0d mismatches %0d", totalChecks, miscompares);
		if (miscompares == 0 && totalChecks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic issue(hflr_op_t s, logic [7:0] c, logic [3:0] f1, logic [3:0] f2, logic [31:0] w, logic p);
		@(posedge ref_clk);
		opSel <= s;
		opCode <= c;
		firstRegisterField <= f1;
		secondRegisterField <= f2;
		memOperand <= w;
		generalOperand <= w;
		programStatusWord[19] <= p;
		opValid <= 1'b1;
		@(posedge ref_clk);
		opValid <= 1'b0;
		#1;
	endtask
	task automatic expect_out(string n, logic [31:0] d, logic [3:0] cc, logic wr, logic fl);
		`HFLR_CHK(n, 1'b1, done_r)
		`HFLR_CHK(n, cc, condCode_r)
		`HFLR_CHK(n, wr, destWrite_r)
		`HFLR_CHK(n, fl, fault_r)
		if (wr) `HFLR_CHK(n, d, destData_r)
	endtask
	task automatic rd(string n, logic [3:0] f, logic [31:0] e);
		@(posedge ref_clk) readField <= f;
		@(posedge ref_clk) #1;
		`HFLR_CHK(n, e, readSingle_r)
	endtask
	task automatic t_load();
		// memory operand handed over as one aligned fullword
		issue(OP_LOAD_FLOAT_MEMORY, 8'h68, 4'h8, 4'h0, 32'h4200_1000, 1'b0);
		expect_out("load mem", 32'h4010_0000, 4'h2, 1'b1, 1'b0);
		rd("read odd field", 4'h9, 32'h4010_0000);
		issue(OP_LOAD_FLOAT_FROM_GENERAL, 8'h00, 4'he, 4'h0, 32'hC900_FE12, 1'b0);
		expect_out("load gen", 32'hC7FE_1200, 4'h1, 1'b1, 1'b0);
		issue(OP_LOAD_FLOAT_REGISTER, 8'h00, 4'h2, 4'he, 32'h0, 1'b0);
		expect_out("load reg", 32'hC7FE_1200, 4'h1, 1'b1, 1'b0);
		// opcode alone selects the memory load here
		issue(OP_NONE, 8'h68, 4'h2, 4'h0, 32'h6C00_0000, 1'b0);
		expect_out("zero frac", 32'h0, 4'h0, 1'b1, 1'b0);
		$display("test load done");
	endtask
	task automatic t_under();
		issue(OP_LOAD_FLOAT_MEMORY, 8'h68, 4'he, 4'h0, 32'h0300_00AB, 1'b1);
		expect_out("unf trap", 32'h0, 4'h4, 1'b0, 1'b1);
		`HFLR_CHK("unf cause", 1'b1, faultUnderflow_r)
		rd("unf kept", 4'he, 32'hC7FE_1200);
		issue(OP_LOAD_FLOAT_MEMORY, 8'h68, 4'he, 4'h0, 32'h0300_00AB, 1'b0);
		expect_out("unf masked", 32'h0, 4'h4, 1'b1, 1'b0);
		issue(OP_LOAD_FLOAT_MEMORY, 8'h68, 4'h0, 4'h0, 32'h0400_00AB, 1'b1);
		expect_out("exp -64", 32'h00AB_0000, 4'h2, 1'b1, 1'b0);
		$display("test underflow done");
	endtask
	task automatic t_pos();
		issue(OP_LOAD_FLOAT_FROM_GENERAL, 8'h00, 4'h8, 4'h0, 32'hC119_21EB, 1'b0);
		issue(OP_LOAD_FLOAT_POSITIVE, 8'h00, 4'h6, 4'h8, 32'h0, 1'b0);
		expect_out("pos", 32'h4119_21EB, 4'h2, 1'b1, 1'b0);
		issue(OP_LOAD_GENERAL_FROM_FLOAT, 8'h00, 4'h3, 4'h6, 32'h0, 1'b0);
		`HFLR_CHK("gen write", 1'b1, genWrite_r)
		`HFLR_CHK("gen field", 4'h3, genField_r)
		`HFLR_CHK("gen data", 32'h4119_21EB, genData_r)
		`HFLR_CHK("gen done", 1'b1, done_r)
		`HFLR_CHK("gen code", 4'h2, condCode_r)
		$display("test positive done");
	endtask
	task automatic rnd(logic [31:0] w, logic [31:0] g, logic [31:0] ex, logic [3:0] cc, logic fl);
		@(posedge ref_clk);
		intSign <= w[31];
		intExp <= $signed({3'h0, w[30:24]}) - EXP_BIAS;
		intFrac <= w[23:0];
		intGuard <= g;
		issue(OP_ROUND_RESULT, 8'h00, 4'ha, 4'h0, 32'h0, 1'b0);
		expect_out("round", ex, cc, !fl, fl);
		`HFLR_CHK("ovf cause", fl, faultOverflow_r)
	endtask
	task automatic t_round();
		rnd(32'h42AB_CD12, 32'h3268_0000, 32'h42AB_CD12, 4'h2, 1'b0);
		rnd(32'hC118_3756, 32'h8000_0000, 32'hC118_3757, 4'h1, 1'b0);
		rnd(32'h3E26_5739, 32'h8010_0000, 32'h3E26_573A, 4'h2, 1'b0);
		rnd(32'h41FF_FFFF, 32'hF000_0000, 32'h4210_0000, 4'h2, 1'b0);
		rnd(32'h7FFF_FFFF, 32'hF000_0000, 32'h0, 4'h6, 1'b1);
		rnd(32'hFFFF_FFFF, 32'hF000_0000, 32'h0, 4'h5, 1'b1);
		rd("ovf kept", 4'ha, 32'h4210_0000);
		$display("test round done");
	endtask
	task automatic t_dbl();
		@(posedge ref_clk);
		dblField <= 4'h5;
		dblData <= 64'h4112_3456_789A_BCDE;
		dblWrite <= 1'b1;
		@(posedge ref_clk);
		dblWrite <= 1'b0;
		readField <= 4'h4;
		@(posedge ref_clk) #1;
		`HFLR_CHK("dbl read", 64'h4112_3456_789A_BCDE, readDouble_r)
		`HFLR_CHK("dbl apart", 32'h0, readSingle_r)
		$display("test double done");
	endtask
	initial begin
		repeat (10) @(posedge ref_clk);
		nrst <= 1'b1;
		t_load();
		t_under();
		t_pos();
		t_round();
		t_dbl();
		`HFLR_CHK("ovf seen", 2, ovfSeen)
		`HFLR_CHK("unf seen", 1, unfSeen)
		complete_run();
	end
	initial begin
		#100000;
		miscompares++;
		complete_run();
	end
endmodule
